/* File: src/spm_mapper.sv */
// Segment and page address mapper: translation, checking and map table access
`timescale 1ns/1ps
module spm_mapper (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic large_map_i,
   input wire logic ctx_wr_i,
   input wire logic [spm_pkg::CTX_W-1:0] ctx_wdata_i,
   output logic [spm_pkg::CTX_W-1:0] ctx_o,
   input wire logic cpu_req_i,
   input wire spm_pkg::spm_req_t cpu_req_data_i,
   output logic cpu_ack_o,
   output logic cpu_bus_error_o,
   output logic [15:0] cpu_rdata_o,
   input wire logic err_clr_i,
   output logic [spm_pkg::CAUSE_W-1:0] err_cause_o,
   output logic sys_bus_start_o,
   output spm_pkg::spm_bus_t sys_bus_o,
   input wire logic sys_bus_ack_i,
   input wire logic [15:0] sys_bus_rdata_i
);

   // ==========================================================================
   // State
   spm_pkg::spm_state_t state;
   spm_pkg::spm_state_t next_state;
   spm_pkg::spm_req_t req;
   logic large_map;
   logic [spm_pkg::SEG_W-1:0] seg;
   logic [spm_pkg::PID_W-1:0] process_number;

   // ==========================================================================
   // Table ports
   logic [spm_pkg::SEG_IDX_W-1:0] seg_idx;
   logic [spm_pkg::SEG_W-1:0] seg_rdata;
   logic [spm_pkg::PAGE_IDX_W-1:0] page_idx;
   logic [spm_pkg::PAGE_W-1:0] page_rdata;
   logic seg_wr_upper;
   logic seg_wr_lower;
   logic page_wr_upper;
   logic page_wr_lower;
   logic [spm_pkg::PAGE_W-1:0] page_wdata;

   // ==========================================================================
   // Decode of the latched request
   logic map_table_select;
   logic page_map_sel;
   logic [5:0] page_table_base;
   logic extra_page_base_bit;
   logic [3:0] segment_violation_lines;
   logic combined_fault;
   logic page_forbid_flag;
   logic page_io_space_flag;
   logic [11:0] physical_frame_bits;
   logic [15:0] map_rdata;
   logic [15:0] lane_mask;
   logic odd_byte;

   assign process_number = ctx_o[spm_pkg::PID_W-1:0];
   assign page_map_sel = ctx_o[spm_pkg::CTX_PAGE_MAP_SEL];

   // ==========================================================================
   // Strap is caught while reset is held and kept afterwards
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         large_map <= large_map_i;
      end
   end

   // ==========================================================================
   // Context register
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         ctx_o <= spm_pkg::CTX_RESET;
      end else if (ctx_wr_i) begin
         ctx_o <= ctx_wdata_i;
      end
   end

   // ==========================================================================
   // Index formation; in the standard map the enlarged bits are forced to zero
   // so both strappings share the same storage
   always_comb begin
      seg_idx = {process_number, 2'h0, req.addr[21:16]};
      if (large_map) begin
         seg_idx = {process_number, req.addr[23:16]};
      end
      page_table_base = seg[spm_pkg::SEG_BASE_HI:spm_pkg::SEG_BASE_LO];
      extra_page_base_bit = large_map & seg[spm_pkg::SEG_EXTRA_BASE_BIT];
      page_idx = {extra_page_base_bit, page_table_base, req.addr[15:12]};
   end

   // Supervisor and user index the same entries; the function code plays no part
   // in the lookup, only in the check
   assign map_table_select = large_map ? req.map_space : req.addr[spm_pkg::ADDR_MAP_SEL];

   spm_table #(
      .WIDTH(spm_pkg::SEG_W),
      .DEPTH(spm_pkg::SEG_DEPTH),
      .IDX_W(spm_pkg::SEG_IDX_W)
   ) u_seg_table (
      .core_clk_i(core_clk_i),
      .rd_idx_i(seg_idx),
      .rd_data_o(seg_rdata),
      .wr_idx_i(seg_idx),
      .wr_upper_i(seg_wr_upper),
      .wr_lower_i(seg_wr_lower),
      .wr_data_i(req.wdata[spm_pkg::SEG_W-1:0])
   );

   spm_table #(
      .WIDTH(spm_pkg::PAGE_W),
      .DEPTH(spm_pkg::PAGE_DEPTH),
      .IDX_W(spm_pkg::PAGE_IDX_W)
   ) u_page_table (
      .core_clk_i(core_clk_i),
      .rd_idx_i(page_idx),
      .rd_data_o(page_rdata),
      .wr_idx_i(page_idx),
      .wr_upper_i(page_wr_upper),
      .wr_lower_i(page_wr_lower),
      .wr_data_i(page_wdata)
   );

   assign page_forbid_flag = page_rdata[spm_pkg::PAGE_FORBID];
   assign page_io_space_flag = page_rdata[spm_pkg::PAGE_IO];
   assign physical_frame_bits = page_rdata[spm_pkg::PAGE_FRAME_HI:spm_pkg::PAGE_FRAME_LO];

   spm_perm u_perm (
      .rights_i(seg[spm_pkg::SEG_RIGHTS_HI:spm_pkg::SEG_RIGHTS_LO]),
      .forbid_i(page_forbid_flag),
      .fc_i(req.fc),
      .wr_i(req.wr),
      .segment_violation_lines_o(segment_violation_lines),
      .fault_o(combined_fault)
   );

   // ==========================================================================
   // Byte lanes and map read data
   always_comb begin
      lane_mask = {{8{~req.upper_byte_strobe_n}}, {8{~req.lower_byte_strobe_n}}};
      // Unstored top nibble of a segment entry reads as zero
      map_rdata = page_map_sel ? page_rdata : {4'h0, seg_rdata};
      // Lower byte alone is the odd byte of the word
      odd_byte = req.upper_byte_strobe_n & ~req.lower_byte_strobe_n;
   end

   // ==========================================================================
   // Table write strobes: map stores, or flag update of a legal translated cycle
   always_comb begin
      seg_wr_upper = 1'b0;
      seg_wr_lower = 1'b0;
      page_wr_upper = 1'b0;
      page_wr_lower = 1'b0;
      page_wdata = req.wdata;
      if (state == spm_pkg::SPM_CHECK) begin
         if (map_table_select) begin
            if (req.wr && !page_map_sel) begin
               seg_wr_upper = ~req.upper_byte_strobe_n;
               seg_wr_lower = ~req.lower_byte_strobe_n;
            end
            if (req.wr && page_map_sel) begin
               page_wr_upper = ~req.upper_byte_strobe_n;
               page_wr_lower = ~req.lower_byte_strobe_n;
            end
         end else if (!combined_fault) begin
            page_wdata = page_rdata;
            page_wdata[spm_pkg::PAGE_REFERENCED] = 1'b1;
            page_wdata[spm_pkg::PAGE_WRITTEN] = page_rdata[spm_pkg::PAGE_WRITTEN] | req.wr;
            page_wr_upper = 1'b1;
         end
      end
   end

   // ==========================================================================
   // Sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         spm_pkg::SPM_IDLE: begin
            if (cpu_req_i) begin
               next_state = spm_pkg::SPM_LOOK;
            end
         end
         spm_pkg::SPM_LOOK: begin
            next_state = spm_pkg::SPM_CHECK;
         end
         spm_pkg::SPM_CHECK: begin
            if (map_table_select || combined_fault) begin
               next_state = spm_pkg::SPM_DONE;
            end else begin
               next_state = spm_pkg::SPM_BUS;
            end
         end
         spm_pkg::SPM_BUS: begin
            if (sys_bus_ack_i) begin
               next_state = spm_pkg::SPM_DONE;
            end
         end
         spm_pkg::SPM_DONE: begin
            next_state = spm_pkg::SPM_IDLE;
         end
         default: begin
            next_state = spm_pkg::SPM_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         state <= spm_pkg::SPM_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================================
   // Request and segment entry latches
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         req <= '0;
      end else if (state == spm_pkg::SPM_IDLE && cpu_req_i) begin
         req <= cpu_req_data_i;
      end
   end

   // Registering the segment entry splits the two table reads over two cycles
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         seg <= '0;
      end else if (state == spm_pkg::SPM_LOOK) begin
         seg <= seg_rdata;
      end
   end

   // ==========================================================================
   // Processor answer
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         cpu_ack_o <= 1'b0;
         cpu_bus_error_o <= 1'b0;
         cpu_rdata_o <= 16'h0000;
      end else begin
         cpu_ack_o <= 1'b0;
         cpu_bus_error_o <= 1'b0;
         if (state == spm_pkg::SPM_CHECK && map_table_select) begin
            cpu_ack_o <= 1'b1;
            if (!req.wr) begin
               cpu_rdata_o <= map_rdata & lane_mask;
            end
         end else if (state == spm_pkg::SPM_CHECK && combined_fault) begin
            cpu_bus_error_o <= 1'b1;
         end else if (state == spm_pkg::SPM_BUS && sys_bus_ack_i) begin
            cpu_ack_o <= 1'b1;
            if (!req.wr) begin
               cpu_rdata_o <= sys_bus_rdata_i & lane_mask;
            end
         end
      end
   end

   // ==========================================================================
   // Error register; a new fault wins over a clear in the same cycle
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         err_cause_o <= spm_pkg::CAUSE_RESET;
      end else if (state == spm_pkg::SPM_CHECK && !map_table_select && combined_fault) begin
         err_cause_o <= {page_forbid_flag, segment_violation_lines};
      end else if (err_clr_i) begin
         err_cause_o <= spm_pkg::CAUSE_RESET;
      end
   end

   // ==========================================================================
   // Translated system bus cycle, started only after a clean check
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         sys_bus_start_o <= 1'b0;
         sys_bus_o <= '0;
      end else begin
         sys_bus_start_o <= 1'b0;
         if (state == spm_pkg::SPM_CHECK && !map_table_select && !combined_fault) begin
            sys_bus_start_o <= 1'b1;
            sys_bus_o.addr <= {physical_frame_bits, req.addr[11:1], odd_byte};
            sys_bus_o.io <= page_io_space_flag;
            sys_bus_o.wr <= req.wr;
            sys_bus_o.upper_byte_strobe_n <= req.upper_byte_strobe_n;
            sys_bus_o.lower_byte_strobe_n <= req.lower_byte_strobe_n;
            sys_bus_o.wdata <= req.wdata;
         end
      end
   end

endmodule

/* File: src/spm_perm.sv */
// Access check of one translated cycle against segment rights and the page forbid flag
`timescale 1ns/1ps
module spm_perm (
   input wire logic [3:0] rights_i,
   input wire logic forbid_i,
   input wire logic [2:0] fc_i,
   input wire logic wr_i,
   output logic [3:0] segment_violation_lines_o,
   output logic fault_o
);

   logic user;
   logic prog;
   logic data_rd;

   always_comb begin
      user = ~fc_i[spm_pkg::FC_SUPERVISOR];
      // Program space comes from the function code, so PC relative reads land here
      prog = (fc_i[1:0] == spm_pkg::FC_PROG) & ~wr_i;
      data_rd = (fc_i[1:0] == spm_pkg::FC_DATA) & ~wr_i;
      segment_violation_lines_o[spm_pkg::RIGHT_USER] = user & ~rights_i[spm_pkg::RIGHT_USER];
      segment_violation_lines_o[spm_pkg::RIGHT_WRITE] = wr_i & ~rights_i[spm_pkg::RIGHT_WRITE];
      segment_violation_lines_o[spm_pkg::RIGHT_DATA_READ] = data_rd & ~rights_i[spm_pkg::RIGHT_DATA_READ];
      segment_violation_lines_o[spm_pkg::RIGHT_PROG_READ] = prog & ~rights_i[spm_pkg::RIGHT_PROG_READ];
      fault_o = (|segment_violation_lines_o) | forbid_i;
   end

endmodule

/* File: src/spm_pkg.sv */
// Shared constants and types for the segment/page address mapper
package spm_pkg;

   // ==========================================================================
   // Table geometry, sized for the enlarged map strapping
   localparam int SEG_DEPTH = 4096;
   localparam int SEG_IDX_W = 12;
   localparam int SEG_W = 12;
   localparam int PAGE_DEPTH = 2048;
   localparam int PAGE_IDX_W = 11;
   localparam int PAGE_W = 16;
   localparam int PID_W = 4;
   localparam int CTX_W = 8;

   // ==========================================================================
   // Segment entry fields
   localparam int SEG_RIGHTS_HI = 11;
   localparam int SEG_RIGHTS_LO = 8;
   localparam int SEG_EXTRA_BASE_BIT = 7;
   localparam int SEG_BASE_HI = 5;
   localparam int SEG_BASE_LO = 0;
   localparam int RIGHT_USER = 3;
   localparam int RIGHT_WRITE = 2;
   localparam int RIGHT_DATA_READ = 1;
   localparam int RIGHT_PROG_READ = 0;

   // ==========================================================================
   // Page entry fields
   localparam int PAGE_FRAME_HI = 11;
   localparam int PAGE_FRAME_LO = 0;
   localparam int PAGE_REFERENCED = 15;
   localparam int PAGE_WRITTEN = 14;
   localparam int PAGE_FORBID = 13;
   localparam int PAGE_IO = 12;

   // ==========================================================================
   // Address, function code and context fields
   localparam int ADDR_MAP_SEL = 23;
   localparam int CTX_PAGE_MAP_SEL = 4;
   localparam logic [1:0] FC_DATA = 2'h1;
   localparam logic [1:0] FC_PROG = 2'h2;
   localparam int FC_SUPERVISOR = 2;

   // ==========================================================================
   // Reset values and fault cause width
   localparam logic [CTX_W-1:0] CTX_RESET = 8'h00;
   localparam int CAUSE_W = 5;
   localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h00;

   typedef enum logic [2:0] {
      SPM_IDLE = 3'h0,
      SPM_LOOK = 3'h1,
      SPM_CHECK = 3'h3,
      SPM_BUS = 3'h2,
      SPM_DONE = 3'h6
   } spm_state_t;

   typedef struct packed {
      logic [23:1] addr;
      logic wr;
      logic [2:0] fc;
      logic map_space;
      logic upper_byte_strobe_n;
      logic lower_byte_strobe_n;
      logic [15:0] wdata;
   } spm_req_t;

   typedef struct packed {
      logic [23:0] addr;
      logic io;
      logic wr;
      logic upper_byte_strobe_n;
      logic lower_byte_strobe_n;
      logic [15:0] wdata;
   } spm_bus_t;

endpackage

/* File: src/spm_table.sv */
// Flip-flop map table with two byte lanes and a combinational read
`timescale 1ns/1ps
module spm_table #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 1024,
   parameter int IDX_W = 10
) (
   input wire logic core_clk_i,
   input wire logic [IDX_W-1:0] rd_idx_i,
   output logic [WIDTH-1:0] rd_data_o,
   input wire logic [IDX_W-1:0] wr_idx_i,
   input wire logic wr_upper_i,
   input wire logic wr_lower_i,
   input wire logic [WIDTH-1:0] wr_data_i
);

   logic [WIDTH-1:0] mem [DEPTH];

   assign rd_data_o = mem[rd_idx_i];

   // ==========================================================================
   // Lane writes; the upper lane is whatever sits above bit 7
   always_ff @(posedge core_clk_i) begin
      if (wr_lower_i) begin
         mem[wr_idx_i][7:0] <= wr_data_i[7:0];
      end
      if (wr_upper_i) begin
         mem[wr_idx_i][WIDTH-1:8] <= wr_data_i[WIDTH-1:8];
      end
   end

endmodule

/* File: tb/segment_page_address_mapper_tb.sv */
// Self-checking bench for the segment and page address mapper
`timescale 1ns/1ps
module segment_page_address_mapper_tb;
   // ==========================================================================
   // Signals and instances
   logic core_clk_i;
   logic nrst_i = 1'b0;
   logic large_map = 1'b0;
   logic ctx_wr_i = 1'b0;
   logic [7:0] ctx_wdata_i = 8'h00;
   logic [7:0] ctx_o;
   logic cpu_req_i = 1'b0;
   spm_pkg::spm_req_t cpu_req_data_i = '0;
   logic cpu_ack_o;
   logic cpu_bus_error_o;
   logic [15:0] cpu_rdata_o;
   logic err_clr_i = 1'b0;
   logic [4:0] err_cause_o;
   logic sys_bus_start_o;
   spm_pkg::spm_bus_t sys_bus_o;
   logic sys_bus_ack_i;
   logic [15:0] sys_bus_rdata_i;
   logic [3:0] delay = 4'h0;
   spm_pkg::spm_bus_t seen;
   logic [7:0] starts;
   logic [7:0] starts_before;
   logic got_ack;
   logic got_err;
   logic [15:0] got_rdata;
   int mismatches = 0;
   int comparisons = 0;
   int i;
   logic [5:0] pseg [5] = '{6'h05, 6'h05, 6'h05, 6'h06, 6'h05};
   logic [3:0] ppg [5] = '{4'h4, 4'h5, 4'h6, 4'h4, 4'h7};
   logic [15:0] pval [5] = '{16'h0123, 16'h2456, 16'h1789, 16'h0ABC, 16'h0000};
   logic [2:0] rfc [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
   logic [4:0] rcause [4] = '{5'h0A, 5'h08, 5'h02, 5'h00};
   spm_mapper dut (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .large_map_i(large_map), .ctx_wr_i(ctx_wr_i),
      .ctx_wdata_i(ctx_wdata_i), .ctx_o(ctx_o), .cpu_req_i(cpu_req_i), .cpu_req_data_i(cpu_req_data_i),
      .cpu_ack_o(cpu_ack_o), .cpu_bus_error_o(cpu_bus_error_o), .cpu_rdata_o(cpu_rdata_o),
      .err_clr_i(err_clr_i), .err_cause_o(err_cause_o), .sys_bus_start_o(sys_bus_start_o),
      .sys_bus_o(sys_bus_o), .sys_bus_ack_i(sys_bus_ack_i), .sys_bus_rdata_i(sys_bus_rdata_i)
   );
   spm_bus_slave slave (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .start_i(sys_bus_start_o), .bus_i(sys_bus_o),
      .delay_i(delay), .ack_o(sys_bus_ack_i), .rdata_o(sys_bus_rdata_i), .seen_o(seen), .starts_o(starts)
   );
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // ==========================================================================
   // Tasks
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [23:0] la(input logic m, input logic [5:0] s, input logic [3:0] p,
                                      input logic [11:0] o);
      return {m, 1'b0, s, p, o};
   endfunction
   task automatic ctx_write(input logic [7:0] v);
      @(posedge core_clk_i);
      ctx_wr_i <= 1'b1;
      ctx_wdata_i <= v;
      @(posedge core_clk_i);
      ctx_wr_i <= 1'b0;
      #1;
   endtask
   // Lanes are active-low strobes, upper then lower
   task automatic access(input logic [23:0] a, input logic wr, input logic [2:0] fc, input logic [1:0] ln,
                         input logic [15:0] wd, input logic exp_err);
      int n;
      @(posedge core_clk_i);
      cpu_req_i <= 1'b1;
      cpu_req_data_i <= '{addr: a[23:1], wr: wr, fc: fc, map_space: a[23], upper_byte_strobe_n: ln[1],
                          lower_byte_strobe_n: ln[0], wdata: wd};
      @(posedge core_clk_i);
      cpu_req_i <= 1'b0;
      got_ack = 1'b0;
      got_err = 1'b0;
      n = 0;
      while (!got_ack && !got_err && n < 60) begin
         @(posedge core_clk_i);
         #1;
         got_ack = (cpu_ack_o === 1'b1);
         got_err = (cpu_bus_error_o === 1'b1);
         n++;
      end
      got_rdata = cpu_rdata_o;
      check("bus error", 24'(exp_err), 24'(got_err));
      check("ack", 24'(!exp_err), 24'(got_ack));
      @(posedge core_clk_i);
   endtask
   task automatic page_chk(input logic [5:0] s, input logic [3:0] p, input logic [15:0] exp);
      ctx_write(8'h13);
      access(la(1'b1, s, p, 12'h000), 1'b0, 3'h5, 2'b00, 16'h0000, 1'b0);
      check("page entry", 24'(exp), 24'(got_rdata));
      ctx_write(8'h03);
   endtask
   task automatic clear_err();
      @(posedge core_clk_i);
      err_clr_i <= 1'b1;
      @(posedge core_clk_i);
      err_clr_i <= 1'b0;
      #1;
      check("cause clear", 24'h000000, 24'(err_cause_o));
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge core_clk_i);
      mismatches++;
      finish_test();
   end
   // ==========================================================================
   // Tests
   initial begin
      repeat (2) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      ctx_write(8'h02);
      access(la(1'b1, 6'h05, 4'h0, 12'h000), 1'b1, 3'h5, 2'b00, 16'h0F11, 1'b0);
      ctx_write(8'h03);
      check("context", 24'h000003, 24'(ctx_o));
      access(la(1'b1, 6'h05, 4'h0, 12'h000), 1'b1, 3'h5, 2'b00, 16'hFB2A, 1'b0);
      access(la(1'b1, 6'h06, 4'h0, 12'h000), 1'b1, 3'h5, 2'b00, 16'h052B, 1'b0);
      access(la(1'b1, 6'h05, 4'h0, 12'h000), 1'b0, 3'h5, 2'b00, 16'h0000, 1'b0);
      check("segment", 24'h000B2A, 24'(got_rdata));
      access(la(1'b1, 6'h05, 4'h0, 12'h000), 1'b0, 3'h5, 2'b10, 16'h0000, 1'b0);
      check("segment low", 24'h00002A, 24'(got_rdata));
      ctx_write(8'h13);
      for (i = 0; i < 5; i++) begin
         access(la(1'b1, pseg[i], ppg[i], 12'h000), 1'b1, 3'h5, 2'b00, pval[i], 1'b0);
      end
      access(la(1'b1, 6'h05, 4'h7, 12'h000), 1'b1, 3'h5, 2'b01, 16'h0F99, 1'b0);
      page_chk(6'h05, 4'h7, 16'h0F00);
      page_chk(6'h05, 4'h4, 16'h0123);
      $display("test map_tables done");
      access(la(1'b0, 6'h05, 4'h4, 12'h346), 1'b0, 3'h1, 2'b00, 16'h0000, 1'b0);
      check("bus address", 24'h123346, seen.addr);
      check("io", 24'h000000, 24'(seen.io));
      check("read data", 24'h00CCB9, 24'(got_rdata));
      page_chk(6'h05, 4'h4, 16'h8123);
      clear_err();
      access(la(1'b0, 6'h05, 4'h4, 12'h346), 1'b1, 3'h1, 2'b00, 16'h5555, 1'b1);
      check("cause", 24'h000004, 24'(err_cause_o));
      page_chk(6'h05, 4'h4, 16'h8123);
      access(la(1'b0, 6'h06, 4'h4, 12'h010), 1'b1, 3'h5, 2'b00, 16'h1234, 1'b0);
      check("bus write data", 24'h001234, 24'(seen.wdata));
      page_chk(6'h06, 4'h4, 16'hCABC);
      delay <= 4'h5;
      access(la(1'b0, 6'h05, 4'h4, 12'h346), 1'b0, 3'h1, 2'b10, 16'h0000, 1'b0);
      check("byte address", 24'h123347, seen.addr);
      check("byte data", 24'h0000B8, 24'(got_rdata));
      $display("test translation done");
      clear_err();
      starts_before = starts;
      access(la(1'b0, 6'h05, 4'h5, 12'h000), 1'b0, 3'h1, 2'b00, 16'h0000, 1'b1);
      check("cause", 24'h000010, 24'(err_cause_o));
      check("bus starts", 24'(starts_before), 24'(starts));
      page_chk(6'h05, 4'h5, 16'h2456);
      access(la(1'b0, 6'h05, 4'h6, 12'h000), 1'b0, 3'h1, 2'b00, 16'h0000, 1'b0);
      check("io", 24'h000001, 24'(seen.io));
      page_chk(6'h05, 4'h6, 16'h9789);
      $display("test page_flags done");
      for (i = 0; i < 4; i++) begin
         clear_err();
         access(la(1'b0, 6'h06, 4'h4, 12'h020), 1'b0, rfc[i], 2'b00, 16'h0000, rcause[i] != 5'h00);
         check("cause", 24'(rcause[i]), 24'(err_cause_o));
      end
      $display("test rights done");
      // Mid-run reset into the enlarged map; tables keep their contents
      @(posedge core_clk_i);
      nrst_i <= 1'b0;
      large_map <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      #1;
      check("context after reset", 24'h000000, 24'(ctx_o));
      check("cause after reset", 24'h000000, 24'(err_cause_o));
      ctx_write(8'h03);
      access(la(1'b1, 6'h05, 4'h4, 12'h000), 1'b1, 3'h5, 2'b00, 16'h00AA, 1'b0);
      ctx_write(8'h13);
      access(la(1'b1, 6'h05, 4'h4, 12'h000), 1'b1, 3'h5, 2'b00, 16'h0456, 1'b0);
      page_chk(6'h05, 4'h4, 16'h0456);
      access(la(1'b1, 6'h05, 4'h4, 12'h000), 1'b1, 3'h5, 2'b00, 16'h002A, 1'b0);
      page_chk(6'h05, 4'h4, 16'h8123);
      $display("test large_map done");
      finish_test();
   end
endmodule

/* File: tb/spm_bus_slave.sv */
// System bus slave model answering translated cycles after a set delay
`timescale 1ns/1ps
module spm_bus_slave (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic start_i,
   input wire spm_pkg::spm_bus_t bus_i,
   input wire logic [3:0] delay_i,
   output logic ack_o,
   output logic [15:0] rdata_o,
   output spm_pkg::spm_bus_t seen_o,
   output logic [7:0] starts_o
);
   // ==========================================================================
   // Cycle tracking
   logic pending;
   logic [3:0] count;
   logic hit;
   assign hit = nrst_i && !start_i && pending && (count == 4'h0);
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pending <= 1'b0;
         count <= 4'h0;
         seen_o <= '0;
         starts_o <= 8'h00;
      end else if (start_i) begin
         pending <= 1'b1;
         count <= delay_i;
         seen_o <= bus_i;
         starts_o <= starts_o + 8'h01;
      end else if (pending) begin
         pending <= (count != 4'h0);
         count <= count - 4'h1;
      end
   end
   // Data flips outside the ack cycle so stale reads show
   always_ff @(posedge core_clk_i) begin
      ack_o <= hit;
      if (!nrst_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= hit ? ~seen_o.addr[15:0] : ~rdata_o;
      end
   end
endmodule

/* File: tb/spm_mapper_monitor.sv */
// Port-level assertions for the segment and page address mapper
`timescale 1ns/1ps
module spm_mapper_monitor (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic large_map_i,
   input wire logic ctx_wr_i,
   input wire logic [spm_pkg::CTX_W-1:0] ctx_wdata_i,
   input wire logic [spm_pkg::CTX_W-1:0] ctx_o,
   input wire logic cpu_req_i,
   input wire spm_pkg::spm_req_t cpu_req_data_i,
   input wire logic cpu_ack_o,
   input wire logic cpu_bus_error_o,
   input wire logic err_clr_i,
   input wire logic [spm_pkg::CAUSE_W-1:0] err_cause_o,
   input wire logic sys_bus_start_o,
   input wire spm_pkg::spm_bus_t sys_bus_o,
   input wire logic sys_bus_ack_i
);
   // ==========================================================================
   // Helper state
   logic busy;
   logic in_bus;
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         busy <= 1'b0;
      end else if (cpu_ack_o || cpu_bus_error_o) begin
         busy <= 1'b0;
      end else if (cpu_req_i) begin
         busy <= 1'b1;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         in_bus <= 1'b0;
      end else if (sys_bus_start_o) begin
         in_bus <= 1'b1;
      end else if (sys_bus_ack_i) begin
         in_bus <= 1'b0;
      end
   end
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);
   // ==========================================================================
   // Assertions
   property p_map_ack;
      cpu_req_i && !busy && !large_map_i && cpu_req_data_i.addr[23] |-> ##3 cpu_ack_o;
   endproperty
   a_map_ack: assert property (p_map_ack) else $error("map_table_select ack late");
   property p_map_no_bus;
      cpu_req_i && !busy && !large_map_i && cpu_req_data_i.addr[23] |-> (!sys_bus_start_o && !cpu_bus_error_o) [*4];
   endproperty
   a_map_no_bus: assert property (p_map_no_bus) else $error("map_table_select left the map");
   property p_xlate_answer;
      cpu_req_i && !busy && !large_map_i && !cpu_req_data_i.addr[23] |-> ##3 (sys_bus_start_o != cpu_bus_error_o);
   endproperty
   a_xlate_answer: assert property (p_xlate_answer) else $error("no start or fault");
   property p_low_bits;
      sys_bus_start_o |-> sys_bus_o.addr[11:1] == $past(cpu_req_data_i.addr[11:1], 3);
   endproperty
   a_low_bits: assert property (p_low_bits) else $error("offset bits altered");
   property p_ack_after_bus;
      in_bus && sys_bus_ack_i |=> cpu_ack_o;
   endproperty
   a_ack_after_bus: assert property (p_ack_after_bus) else $error("bus done not acked");
   property p_fault;
      cpu_bus_error_o |-> err_cause_o != 5'h00 && !sys_bus_start_o;
   endproperty
   a_fault: assert property (p_fault) else $error("fault without cause");
   property p_clear;
      err_clr_i && !busy |=> err_cause_o == 5'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("cause not cleared");
   property p_ctx;
      ctx_wr_i |=> ctx_o == $past(ctx_wdata_i);
   endproperty
   a_ctx: assert property (p_ctx) else $error("context not loaded");
endmodule

bind spm_mapper spm_mapper_monitor u_mon (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .large_map_i(large_map_i), .ctx_wr_i(ctx_wr_i),
   .ctx_wdata_i(ctx_wdata_i), .ctx_o(ctx_o), .cpu_req_i(cpu_req_i), .cpu_req_data_i(cpu_req_data_i),
   .cpu_ack_o(cpu_ack_o), .cpu_bus_error_o(cpu_bus_error_o), .err_clr_i(err_clr_i),
   .err_cause_o(err_cause_o), .sys_bus_start_o(sys_bus_start_o), .sys_bus_o(sys_bus_o),
   .sys_bus_ack_i(sys_bus_ack_i)
);
